/* verilog/aoc_map.svh */
// offsets, field positions, reset values and counts of the offset compensation block
`ifndef AOC_MAP_SVH
`define AOC_MAP_SVH
`define AOC_ADDR_CTRL 8'h36
`define AOC_ADDR_SET 8'h37
`define AOC_ADDR_OFSX 8'h38
`define AOC_ADDR_OFSY 8'h39
`define AOC_ADDR_OFSZ 8'h3a
`define AOC_CTRL_CLR_BIT 7
`define AOC_CTRL_TRIG_HI 6
`define AOC_CTRL_TRIG_LO 5
`define AOC_CTRL_EN_MASK 8'h07
`define AOC_SET_MASK 8'h7f
`define AOC_SET_CUT_BIT 0
`define AOC_RST_CTRL 3'h0
`define AOC_RST_SET 7'h00
`define AOC_RST_OFS 8'h00
// samples averaged by one fast run, as a power of two
`define AOC_FAST_LOG2 5'h04
`define AOC_FAST_LAST 4'hf
// corner ratio: 1000 Hz / 1 Hz and 1000 Hz / 10 Hz, in samples per slow step
`define AOC_SLOW_DIV_LO 10'h3e8
`define AOC_SLOW_DIV_HI 10'h064
// one offset step is 1/128 g; at the 2 g range one g is 4096 data counts
`define AOC_OFS_SHIFT_2G 3'h5
`define AOC_ONE_G_2G 15'h1000
`define AOC_TGT_ONE_G 13'h0080
`endif

/* verilog/aoc_pkg.sv */
// types shared by the offset compensation core and its axis lanes
package aoc_pkg;
  typedef enum logic [2:0] {
    AOC_IDLE = 3'b001,
    AOC_ACC = 3'b010,
    AOC_WRITE = 3'b100
  } aoc_fast_t;
  typedef struct packed {
    logic [2:0] en;
    logic [6:0] set;
    logic [2:0][7:0] ofs;
    aoc_fast_t fst;
    logic [1:0] axis;
    logic [3:0] cnt;
    logic signed [17:0] sum;
    logic [9:0] div;
    logic restore;
    logic [7:0] rdata;
  } aoc_core_state_t;
  typedef struct packed {
    logic signed [13:0] comp_raw;
    logic signed [13:0] comp_flt;
  } aoc_lane_state_t;
endpackage

/* verilog/aoc_lane_if.sv */
// signals between the compensation core and one axis lane
`timescale 1ns/1ps
interface aoc_lane_if;
  logic signed [13:0] raw;
  logic signed [13:0] flt;
  logic signed [7:0] ofs;
  logic [1:0] range;
  logic [1:0] target;
  logic signed [13:0] comp_raw;
  logic signed [13:0] comp_flt;
  logic above;
  logic below;
  modport core (output raw, flt, ofs, range, target, input comp_raw, comp_flt, above, below);
  modport lane (input raw, flt, ofs, range, target, output comp_raw, comp_flt, above, below);
endinterface

/* verilog/aoc_lane.sv */
// one axis lane: subtracts the correction from filtered and raw data
`timescale 1ns/1ps
`include "aoc_map.svh"
module aoc_lane (
  input wire logic clock,
  input wire logic rst,
  aoc_lane_if.lane lp
);
  aoc_pkg::aoc_lane_state_t q;
  aoc_pkg::aoc_lane_state_t d;
  logic [2:0] sh;
  logic signed [15:0] ofs_l;
  logic signed [14:0] one_g;
  logic signed [14:0] tgt;

  function automatic logic signed [13:0] sat14(input logic signed [16:0] v);
    if (v > 17'sh01fff) begin
      return 14'sh1fff;
    end else if (v < -17'sh02000) begin
      return 14'sh2000;
    end
    return v[13:0];
  endfunction

  // correction scaled to data counts; step stays 1/128 g on every range
  always_comb begin
    sh = 3'(`AOC_OFS_SHIFT_2G - {1'b0, lp.range});
    ofs_l = 16'(lp.ofs) <<< sh;
    d.comp_raw = sat14(17'(lp.raw) - 17'(ofs_l));
    d.comp_flt = sat14(17'(lp.flt) - 17'(ofs_l));
    one_g = `AOC_ONE_G_2G >> lp.range;
    case (lp.target)
      2'b01: tgt = one_g;
      2'b10: tgt = -one_g;
      default: tgt = 15'sh0000;
    endcase
  end

  // error sign against the target steers the slow loop
  assign lp.above = 15'(q.comp_raw) > tgt;
  assign lp.below = 15'(q.comp_raw) < tgt;
  assign lp.comp_raw = q.comp_raw;
  assign lp.comp_flt = q.comp_flt;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  property p_zero_pass;
    @(posedge clock) disable iff (rst)
    lp.ofs == 8'sh00 |=> q.comp_raw == $past(lp.raw) && q.comp_flt == $past(lp.flt);
  endproperty
  a_zero_pass: assert property (p_zero_pass) else $error("zero correction altered data");
endmodule

/* verilog/aoc_top.sv */
// offset compensation core: registers, fast and slow loops, three lanes
`timescale 1ns/1ps
`include "aoc_map.svh"
module aoc_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [1:0] acc_range,
  input wire logic [2:0][13:0] acc_raw,
  input wire logic [2:0][13:0] acc_filt,
  output logic [2:0][13:0] comp_raw,
  output logic [2:0][13:0] comp_filt,
  input wire logic nvm_restore,
  input wire logic [2:0][7:0] nvm_ofs,
  output logic [2:0][7:0] ofs_out,
  output logic fast_ready
);
  localparam aoc_pkg::aoc_core_state_t CORE_RST = '{
    en: `AOC_RST_CTRL,
    set: `AOC_RST_SET,
    ofs: {3{`AOC_RST_OFS}},
    fst: aoc_pkg::AOC_IDLE,
    axis: 2'h0,
    cnt: 4'h0,
    sum: 18'sh00000,
    div: 10'h000,
    restore: 1'b1,
    rdata: 8'h00
  };

  aoc_pkg::aoc_core_state_t q;
  aoc_pkg::aoc_core_state_t d;
  logic wr_ctrl;
  logic wr_set;
  logic [1:0] trig;
  logic trig_ok;
  logic fast_wr;
  logic slow_tick;
  logic reloading;
  logic [1:0] idx;
  logic [2:0] sh;
  logic [1:0] tcode;
  logic signed [12:0] tgt;
  logic signed [17:0] avg;
  logic signed [12:0] fv;
  logic [7:0] fast_sat;
  logic [9:0] div_lim;
  logic [2:0] above;
  logic [2:0] below;

  // one lane per axis; each carries its correction and target code
  for (genvar i = 0; i < 3; i++) begin : g_lane
    aoc_lane_if lif ();
    assign lif.raw = acc_raw[i];
    assign lif.flt = acc_filt[i];
    assign lif.ofs = q.ofs[i];
    assign lif.range = acc_range;
    assign lif.target = q.set[2 * i + 1 +: 2];
    assign comp_raw[i] = lif.comp_raw;
    assign comp_filt[i] = lif.comp_flt;
    assign above[i] = lif.above;
    assign below[i] = lif.below;
    aoc_lane u_lane (
      .clock(clock),
      .rst(rst),
      .lp(lif.lane)
    );
  end

  // register decode
  always_comb begin
    wr_ctrl = reg_wr && reg_addr == `AOC_ADDR_CTRL;
    wr_set = reg_wr && reg_addr == `AOC_ADDR_SET;
    trig = reg_wdata[`AOC_CTRL_TRIG_HI:`AOC_CTRL_TRIG_LO];
    // a trigger while busy is dropped, the run in flight is kept
    trig_ok = wr_ctrl && trig != 2'b00 && q.fst == aoc_pkg::AOC_IDLE;
    reloading = q.restore || nvm_restore;
  end

  // fast result: mean of the run in 1/128 g steps, minus the target
  always_comb begin
    idx = 2'(q.axis - 2'h1);
    sh = 3'(`AOC_OFS_SHIFT_2G - {1'b0, acc_range});
    tcode = q.set[2 * idx + 1 +: 2];
    case (tcode)
      2'b01: tgt = `AOC_TGT_ONE_G;
      2'b10: tgt = -`AOC_TGT_ONE_G;
      default: tgt = 13'sh0000;
    endcase
    avg = q.sum >>> (`AOC_FAST_LOG2 + 5'(sh));
    fv = 13'(avg) - tgt;
    // saturate so a large offset pins at the ends instead of wrapping
    if (fv > 13'sh007f) begin
      fast_sat = 8'h7f;
    end else if (fv < 13'sh1f80) begin
      fast_sat = 8'h80;
    end else begin
      fast_sat = fv[7:0];
    end
    div_lim = q.set[`AOC_SET_CUT_BIT] ? `AOC_SLOW_DIV_HI : `AOC_SLOW_DIV_LO;
  end

  // next state of the whole core
  always_comb begin
    d = q;
    fast_wr = 1'b0;
    slow_tick = 1'b0;
    d.rdata = 8'h00;

    // slow loop paced by the sample rate, so its corner follows bandwidth
    if (sample_valid) begin
      if (q.div >= 10'(div_lim - 10'h001)) begin
        d.div = 10'h000;
        slow_tick = 1'b1;
      end else begin
        d.div = 10'(q.div + 10'h001);
      end
    end
    // slow loop rests during a fast run so the two never fight
    if (slow_tick && q.fst == aoc_pkg::AOC_IDLE) begin
      for (int i = 0; i < 3; i++) begin
        if (q.en[i]) begin
          if (above[i] && q.ofs[i] != 8'h7f) begin
            d.ofs[i] = 8'(q.ofs[i] + 8'h01);
          end else if (below[i] && q.ofs[i] != 8'h80) begin
            d.ofs[i] = 8'(q.ofs[i] - 8'h01);
          end
        end
      end
    end

    // software writes
    if (wr_ctrl) begin
      d.en = 3'(reg_wdata & `AOC_CTRL_EN_MASK);
    end
    if (wr_set) begin
      d.set = 7'(reg_wdata & `AOC_SET_MASK);
      d.div = 10'h000; // a new corner starts from a fresh count, never past its end
    end
    if (reg_wr && reg_addr == `AOC_ADDR_OFSX) begin
      d.ofs[0] = reg_wdata;
    end
    if (reg_wr && reg_addr == `AOC_ADDR_OFSY) begin
      d.ofs[1] = reg_wdata;
    end
    if (reg_wr && reg_addr == `AOC_ADDR_OFSZ) begin
      d.ofs[2] = reg_wdata;
    end
    if (wr_ctrl && reg_wdata[`AOC_CTRL_CLR_BIT]) begin
      d.ofs = {3{`AOC_RST_OFS}};
    end

    // fast compensation sequence
    case (q.fst)
      aoc_pkg::AOC_IDLE: begin
        if (trig_ok) begin
          d.fst = aoc_pkg::AOC_ACC;
          d.axis = trig;
          d.cnt = 4'h0;
          d.sum = 18'sh00000;
        end
      end
      aoc_pkg::AOC_ACC: begin
        if (sample_valid) begin
          d.sum = q.sum + 18'(signed'(acc_raw[idx]));
          d.cnt = 4'(q.cnt + 4'h1);
          if (q.cnt == `AOC_FAST_LAST) begin
            d.fst = aoc_pkg::AOC_WRITE;
          end
        end
      end
      aoc_pkg::AOC_WRITE: begin
        // the result beats a same-cycle software write or clear
        fast_wr = 1'b1;
        d.ofs[idx] = fast_sat;
        d.fst = aoc_pkg::AOC_IDLE;
      end
      default: begin
        d.fst = aoc_pkg::AOC_IDLE;
      end
    endcase

    // reload from the store once after reset and on every soft reset
    if (reloading) begin
      d.ofs = nvm_ofs;
      d.restore = 1'b0;
    end

    // read port, data valid only in the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        `AOC_ADDR_CTRL: d.rdata = {3'h0, fast_ready, 1'b0, q.en};
        `AOC_ADDR_SET: d.rdata = {1'b0, q.set};
        `AOC_ADDR_OFSX: d.rdata = q.ofs[0];
        `AOC_ADDR_OFSY: d.rdata = q.ofs[1];
        `AOC_ADDR_OFSZ: d.rdata = q.ofs[2];
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= CORE_RST;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign fast_ready = q.fst == aoc_pkg::AOC_IDLE;
  assign reg_rdata = q.rdata;
  assign ofs_out = q.ofs;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_trig_taken;
    wr_ctrl && trig != 2'b00 && fast_ready;
  endsequence

  sequence s_quiet;
    !reg_wr && !fast_wr && !reloading;
  endsequence

  property p_clear_all;
    wr_ctrl && reg_wdata[`AOC_CTRL_CLR_BIT] && !fast_wr && !reloading |=> q.ofs == 24'h000000;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear-all left a correction set");

  property p_trig_start;
    s_trig_taken |=> !fast_ready && q.axis == $past(trig);
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("accepted trigger did not start a run");

  property p_no_trig;
    wr_ctrl && trig == 2'b00 && fast_ready |=> fast_ready;
  endproperty
  a_no_trig: assert property (p_no_trig) else $error("code 00 started a run");

  property p_ready_back;
    $rose(fast_ready) |-> $past(fast_wr);
  endproperty
  a_ready_back: assert property (p_ready_back) else $error("ready rose without a result");

  property p_busy_hold;
    q.fst == aoc_pkg::AOC_ACC && !sample_valid |=> !fast_ready;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("ready rose during a run");

  property p_fast_result;
    fast_wr && !reloading |=> q.ofs[$past(idx)] == $past(fast_sat);
  endproperty
  a_fast_result: assert property (p_fast_result) else $error("fast result not stored");

  property p_slow_off;
    slow_tick && !q.en[0] ##0 s_quiet |=> $stable(q.ofs[0]);
  endproperty
  a_slow_off: assert property (p_slow_off) else $error("disabled x axis moved");

  property p_slow_rate;
    slow_tick |=> !slow_tick [*8];
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow steps too close");

  property p_slow_point;
    slow_tick |-> q.div == 10'(div_lim - 10'h001);
  endproperty
  a_slow_point: assert property (p_slow_point) else $error("slow step off its divide point");

  property p_restore;
    reloading |=> q.ofs == $past(nvm_ofs);
  endproperty
  a_restore: assert property (p_restore) else $error("store reload missed");

  property p_slow_off_y;
    slow_tick && !q.en[1] ##0 s_quiet |=> $stable(q.ofs[1]);
  endproperty
  a_slow_off_y: assert property (p_slow_off_y) else $error("disabled y axis moved");

  property p_slow_up;
    slow_tick && q.en[0] && fast_ready && above[0] && q.ofs[0] != 8'h7f ##0 s_quiet
      |=> q.ofs[0] == 8'($past(q.ofs[0]) + 8'h01);
  endproperty
  a_slow_up: assert property (p_slow_up) else $error("enabled x axis did not step up");

  property p_en_write;
    wr_ctrl |=> q.en == $past(reg_wdata[2:0]);
  endproperty
  a_en_write: assert property (p_en_write) else $error("slow enables not stored");

  property p_set_write;
    wr_set |=> q.set == $past(reg_wdata[6:0]);
  endproperty
  a_set_write: assert property (p_set_write) else $error("settings not stored");

  property p_sw_write;
    reg_wr && reg_addr == `AOC_ADDR_OFSX && !fast_wr && !reloading |=> q.ofs[0] == $past(reg_wdata);
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("software x write not stored");

  property p_read_x;
    reg_rd && reg_addr == `AOC_ADDR_OFSX |=> reg_rdata == $past(q.ofs[0]);
  endproperty
  a_read_x: assert property (p_read_x) else $error("x correction read back wrong");

  property p_ctrl_read;
    reg_rd && reg_addr == `AOC_ADDR_CTRL |=> reg_rdata[4] == $past(fast_ready) && reg_rdata[7:5] == 3'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("ready flag read back wrong");

  property p_no_restart;
    wr_ctrl && trig != 2'b00 && !fast_ready |=> q.axis == $past(q.axis);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("busy trigger changed the axis");

  property p_write_done;
    q.fst == aoc_pkg::AOC_WRITE |=> fast_ready;
  endproperty
  a_write_done: assert property (p_write_done) else $error("ready not back after result");
endmodule

/* test/tb.sv */
// self-checking bench for the offset compensation core, driven through its register port
`timescale 1ns/1ps
module tb;
  logic clock, rst, reg_wr, reg_rd, sample_valid, nvm_restore, fast_ready;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [1:0] acc_range;
  logic [2:0][13:0] acc_raw, acc_filt, comp_raw, comp_filt;
  logic [2:0][7:0] nvm_ofs, ofs_out;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int k;
  logic [1:0] axes [4] = '{2'h1, 2'h2, 2'h3, 2'h1};
  logic [1:0] tgts [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  // 320 counts averaged at 2 g range is 10 steps, then the target is taken off and saturated
  logic [7:0] exp_ofs [4] = '{8'h8a, 8'h7f, 8'h0a, 8'h0a};

  aoc_top u_dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .acc_range(acc_range), .acc_raw(acc_raw), .acc_filt(acc_filt), .comp_raw(comp_raw),
    .comp_filt(comp_filt), .nvm_restore(nvm_restore), .nvm_ofs(nvm_ofs), .ofs_out(ofs_out),
    .fast_ready(fast_ready));

  // 20 ns clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // hang guard, far above the roughly 2500 cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock);
      sample_valid <= 1'b1;
      @(posedge clock);
      sample_valid <= 1'b0;
    end
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
  endtask

  initial begin
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sample_valid = 1'b0;
    nvm_restore = 1'b0;
    acc_range = 2'h0;
    acc_raw = '0;
    acc_filt = '0;
    nvm_ofs = {8'h33, 8'hc4, 8'h7f};
    do_reset();
    rd(8'h38, 8'h7f);
    rd(8'h39, 8'hc4);
    rd(8'h3a, 8'h33);
    rd(8'h36, 8'h10);
    rd(8'h37, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h37, 8'h7f);
    rd(8'h37, 8'h7f);
    wr(8'h36, 8'h07);
    rd(8'h36, 8'h17);
    $display("test registers done");
    // subtraction at every range; the step size must not follow the range
    wr(8'h36, 8'h00);
    wr(8'h38, 8'h10);
    for (int r = 0; r < 4; r++) begin
      @(posedge clock);
      acc_range <= 2'(r);
      acc_raw[0] <= 14'h03e8;
      acc_filt[0] <= 14'h07d0;
      repeat (2) @(posedge clock);
      #1;
      chk(comp_raw[0], 14'(1000 - (16 << (5 - r))));
      chk(comp_filt[0], 14'(2000 - (16 << (5 - r))));
      chk(comp_raw[1], 14'(60 << (5 - r)));
      chk(comp_filt[1], 14'(60 << (5 - r)));
      chk(comp_raw[2], 14'(-(51 << (5 - r))));
      chk(comp_filt[2], 14'(-(51 << (5 - r))));
    end
    wr(8'h38, 8'h80);
    repeat (2) @(posedge clock);
    #1;
    chk(comp_raw[0], 14'h05e8);
    $display("test subtraction done");
    // soft reload, then clear-all with zero and one
    @(posedge clock);
    nvm_ofs[0] <= 8'h5a;
    @(posedge clock);
    nvm_restore <= 1'b1;
    @(posedge clock);
    nvm_restore <= 1'b0;
    rd(8'h38, 8'h5a);
    wr(8'h36, 8'h00);
    rd(8'h39, 8'hc4);
    wr(8'h36, 8'h80);
    rd(8'h38, 8'h00);
    rd(8'h39, 8'h00);
    rd(8'h3a, 8'h00);
    $display("test reload and clear done");
    // fast runs on every axis and target code, with a refused trigger in mid-run
    @(posedge clock);
    acc_range <= 2'h0;
    acc_raw <= {14'h0140, 14'h0140, 14'h0140};
    wr(8'h36, 8'h00);
    #1;
    chk(fast_ready, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(8'h37, 8'({6'h00, tgts[i]} << (2 * axes[i] - 1)));
      wr(8'h36, {1'b0, axes[i], 5'h00});
      #1;
      chk(fast_ready, 1'b0);
      pulse(8);
      wr(8'h36, 8'h60);
      #1;
      chk(fast_ready, 1'b0);
      pulse(8);
      k = 0;
      // look after the edge so the flag has settled
      while (fast_ready !== 1'b1 && k < 10) begin
        @(posedge clock);
        #1;
        k++;
      end
      chk(fast_ready, 1'b1);
      rd(8'h37 + 8'(axes[i]), exp_ofs[i]);
    end
    chk(ofs_out[0], 8'h0a);
    $display("test fast compensation done");
    // slow steps at both corner settings; the disabled axis must hold still
    @(posedge clock);
    nvm_ofs <= '0;
    do_reset();
    rd(8'h36, 8'h10);
    @(posedge clock);
    acc_raw <= {14'h0140, 14'h03e8, 14'h03e8};
    wr(8'h37, 8'h01);
    wr(8'h36, 8'h01);
    pulse(99);
    rd(8'h38, 8'h00);
    pulse(1);
    rd(8'h38, 8'h01);
    rd(8'h39, 8'h00);
    wr(8'h37, 8'h00);
    pulse(999);
    rd(8'h38, 8'h01);
    pulse(1);
    rd(8'h38, 8'h02);
    $display("test slow compensation done");
    test_done();
  end
endmodule
